// ==== rtl/sac_pkg.sv ====
// shared constants, types and decode functions for the converter control block
package sac_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// register indexes; byte address is four times the index
	localparam logic [9:0] CTL_IDX = 10'h01F;
	localparam logic [9:0] PCFG_IDX = 10'h09F;
	localparam logic [9:0] RES_IDX = 10'h01E;
	localparam logic [9:0] STAT_IDX = 10'h00C;
	// control register field positions
	localparam int CLK_SEL_LSB = 6;
	localparam int CHAN_LSB = 3;
	localparam int GO_BIT = 2;
	localparam int PWR_BIT = 0;
	localparam int DONE_BIT = 0;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [2:0] PCFG_RESET = 3'h0;
	localparam logic [7:0] RES_RESET = 8'h00;
	// conversion clock select codes
	localparam logic [1:0] SEL_DIV2 = 2'h0;
	localparam logic [1:0] SEL_DIV8 = 2'h1;
	localparam logic [1:0] SEL_DIV32 = 2'h2;
	localparam logic [1:0] SEL_RC = 2'h3;
	localparam int DIV2_CYC = 2;
	localparam int DIV8_CYC = 8;
	localparam int DIV32_CYC = 32;
	// internal rc oscillator typical bit period, in ns, and system clock period
	localparam int CLK_PERIOD_NS = 10;
	localparam int RC_PERIOD_NS = 4000;
	localparam int RC_CYC = RC_PERIOD_NS / CLK_PERIOD_NS;
	// one instruction cycle of four oscillator periods before an rc conversion
	localparam int START_WAIT_CYC = 4;
	localparam int RESULT_W = 8;
	localparam int BIT_PERIODS = 9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// signals toward the analog front end
	typedef struct packed {
		logic conv_on;
		logic ref_external;
		logic route_en;
		logic [2:0] channel;
		logic [7:0] analog_mask;
		logic sample;
		logic [7:0] dac_code;
	} sac_ana_t;

	// port configuration: analog pin mask, ordered channel 0..7
	function automatic logic [7:0] pcfg_mask(input logic [2:0] cfg);
		logic [7:0] m;
		m = 8'h00;
		case (cfg)
			3'h0: m = 8'hFF;
			3'h1: m = 8'hF7;
			3'h2: m = 8'h1F;
			3'h3: m = 8'h17;
			3'h4: m = 8'h0B;
			3'h5: m = 8'h03;
			default: m = 8'h00;
		endcase
		return m;
	endfunction : pcfg_mask

	// odd codes below 6 take the reference from the shared input 3 pin
	function automatic logic pcfg_ref_ext(input logic [2:0] cfg);
		return cfg[0] & ~(cfg[2] & cfg[1]);
	endfunction : pcfg_ref_ext

	function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
		return addr[ADDR_W-1:2] == idx;
	endfunction : idx_hit
endpackage : sac_pkg

// ==== rtl/sac_clk_div.sv ====
// conversion clock divider: one-cycle bit period enable
`timescale 1ns/100ps
module sac_clk_div #(
	parameter int RC_DIV = sac_pkg::RC_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [1:0] sel,
	output logic tick
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic tick_q;
	logic tick_d;
	logic [15:0] limit;

	////////////////////////////////////////////////////////////////
	// counter restarts while idle so the first period is a full one
	always_comb
	begin
		case (sel)
			sac_pkg::SEL_DIV2: limit = 16'(sac_pkg::DIV2_CYC);
			sac_pkg::SEL_DIV8: limit = 16'(sac_pkg::DIV8_CYC);
			sac_pkg::SEL_DIV32: limit = 16'(sac_pkg::DIV32_CYC);
			default: limit = 16'(RC_DIV);
		endcase
		cnt_d = cnt_q + 16'h0001;
		tick_d = 1'b0;
		if (!run)
			cnt_d = 16'h0000;
		else if (cnt_q >= limit - 16'h0001)
		begin
			cnt_d = 16'h0000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule : sac_clk_div

// ==== rtl/sac_sar_core.sv ====
// successive-approximation search engine, one step per bit period
`timescale 1ns/100ps
module sac_sar_core #(
	parameter int RES_W = sac_pkg::RESULT_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic start,
	input wire logic abort,
	input wire logic comp_high,
	output logic busy,
	output logic done,
	output logic sample,
	output logic [RES_W-1:0] dac_code,
	output logic [RES_W-1:0] result
);
	typedef enum logic [2:0] {
		SAC_IDLE = 3'b001,
		SAC_SAMPLE = 3'b010,
		SAC_CONV = 3'b100
	} sac_core_st_t;

	sac_core_st_t st_q;
	sac_core_st_t st_d;
	logic [RES_W-1:0] trial_q;
	logic [RES_W-1:0] trial_d;
	logic [RES_W-1:0] bit_q;
	logic [RES_W-1:0] bit_d;
	logic [RES_W-1:0] res_q;
	logic [RES_W-1:0] res_d;
	logic done_q;
	logic done_d;

	////////////////////////////////////////////////////////////////
	// one period of sampling, then one decision per bit, msb first
	always_comb
	begin
		st_d = st_q;
		trial_d = trial_q;
		bit_d = bit_q;
		res_d = res_q;
		done_d = 1'b0;
		case (st_q)
			SAC_IDLE:
			begin
				if (start)
					st_d = SAC_SAMPLE;
			end
			SAC_SAMPLE:
			begin
				if (tick)
				begin
					st_d = SAC_CONV;
					bit_d = {1'b1, {(RES_W-1){1'b0}}};
					trial_d = {1'b1, {(RES_W-1){1'b0}}};
				end
			end
			SAC_CONV:
			begin
				if (tick)
				begin
					// keep the trial bit only when the held level reaches the dac
					trial_d = comp_high ? trial_q : (trial_q & ~bit_q);
					bit_d = bit_q >> 1;
					trial_d = trial_d | (bit_q >> 1);
					if (bit_q[0])
					begin
						st_d = SAC_IDLE;
						res_d = comp_high ? trial_q : (trial_q & ~bit_q);
						done_d = 1'b1;
					end
				end
			end
			default: st_d = SAC_IDLE;
		endcase
		// abort drops the search with no result and no done
		if (abort)
		begin
			st_d = SAC_IDLE;
			done_d = 1'b0;
			res_d = res_q;
		end
		else if (start && st_q != SAC_IDLE)
			st_d = SAC_SAMPLE;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q <= SAC_IDLE;
			trial_q <= '0;
			bit_q <= '0;
			res_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			trial_q <= trial_d;
			bit_q <= bit_d;
			res_q <= res_d;
			done_q <= done_d;
		end
	end

	assign busy = st_q != SAC_IDLE;
	assign sample = st_q == SAC_SAMPLE;
	assign dac_code = (st_q == SAC_CONV) ? trial_q : '0;
	assign done = done_q;
	assign result = res_q;
endmodule : sac_sar_core

// ==== rtl/sac_top.sv ====
// converter control: axi4-lite registers, sleep handling, analog front-end control
`timescale 1ns/100ps
// Function
// - produce an unsigned eight-bit result
// - successive approximation on the held sample
// - reference from supply or input 3 pin
// - conversion may finish during sleep
// - sleep conversion only with rc clock
// - five or eight channels by variant
// - pins analog or digital, input 3 reference
// - go starts; done writes result, flags
// - clearing go aborts, no result, no flag
// - nine bit periods per conversion
// - select code three picks rc oscillator
module sac_top #(
	parameter int NUM_CHANNELS = 8,
	parameter int RC_DIV = sac_pkg::RC_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [sac_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sac_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_mode,
	input wire logic comp_pin,
	output sac_pkg::sac_ana_t ana
);
	////////////////////////////////////////////////////////////////
	// declarations
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [sac_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wlane_q, wlane_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic wr_fire;
	logic wr_ctl, wr_pcfg, wr_stat;
	logic [1:0] clk_sel_q, clk_sel_d;
	logic [2:0] chan_q, chan_d;
	logic go_q, go_d, power_q, power_d;
	logic [2:0] pcfg_q, pcfg_d;
	logic [7:0] result_q, result_d;
	logic done_flag_q, done_flag_d;
	logic [2:0] wait_q, wait_d;
	logic pend_q, pend_d;
	logic start_q, start_d;
	logic sleep_kill;
	logic sw_go;
	logic abort;
	logic comp_s1_q, comp_s2_q, comp_s3_q, comp_f_q, comp_f_d;
	logic tick, busy, core_done, core_sample;
	logic [7:0] core_dac, core_res;
	sac_pkg::sac_ana_t ana_q, ana_d;

	////////////////////////////////////////////////////////////////
	// axi4-lite write: address and data taken in either order, answered two cycles after both
	always_comb
	begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		awaddr_d = awaddr_q;
		wbyte_d = wbyte_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && awready_q)
		begin
			aw_hold_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q)
		begin
			w_hold_d = 1'b1;
			wbyte_d = s_axi_wdata[7:0]; // registers live in byte lane 0 only
			wlane_d = s_axi_wstrb[0];
		end
		if (wr_fire)
		begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (wr_ctl || wr_pcfg || wr_stat || sac_pkg::idx_hit(awaddr_q, sac_pkg::RES_IDX)) ?
				sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d = !w_hold_d && !bvalid_d;
	end

	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_ctl = wr_fire && sac_pkg::idx_hit(awaddr_q, sac_pkg::CTL_IDX);
	assign wr_pcfg = wr_fire && sac_pkg::idx_hit(awaddr_q, sac_pkg::PCFG_IDX);
	assign wr_stat = wr_fire && sac_pkg::idx_hit(awaddr_q, sac_pkg::STAT_IDX);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= sac_pkg::RESP_OKAY;
		end
		else
		begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wbyte_q <= wbyte_d;
			wlane_q <= wlane_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// axi4-lite read: rvalid one cycle after the address is taken, unmapped reads zero with slverr
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d = sac_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (sac_pkg::idx_hit(s_axi_araddr, sac_pkg::CTL_IDX))
				rdata_d[7:0] = {clk_sel_q, chan_q, go_q, 1'b0, power_q};
			else if (sac_pkg::idx_hit(s_axi_araddr, sac_pkg::PCFG_IDX))
				rdata_d[2:0] = pcfg_q;
			else if (sac_pkg::idx_hit(s_axi_araddr, sac_pkg::RES_IDX))
				rdata_d[7:0] = result_q;
			else if (sac_pkg::idx_hit(s_axi_araddr, sac_pkg::STAT_IDX))
				rdata_d[sac_pkg::DONE_BIT] = done_flag_q;
			else
				rresp_d = sac_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= sac_pkg::RESP_OKAY;
		end
		else
		begin
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// control state: go, power, channel, clock select, port config, result, done flag
	// sleep kills a conversion unless the rc clock runs it; power bit itself stays set
	assign sleep_kill = sleep_mode && (clk_sel_q != sac_pkg::SEL_RC);
	// go is only accepted once the converter is already powered
	assign sw_go = wr_ctl && wlane_q && wbyte_q[sac_pkg::GO_BIT] && power_q;

	always_comb
	begin
		clk_sel_d = clk_sel_q;
		chan_d = chan_q;
		power_d = power_q;
		pcfg_d = pcfg_q;
		go_d = go_q;
		result_d = result_q;
		done_flag_d = done_flag_q;
		if (wr_ctl && wlane_q)
		begin
			clk_sel_d = wbyte_q[sac_pkg::CLK_SEL_LSB +: 2];
			chan_d = wbyte_q[sac_pkg::CHAN_LSB +: 3];
			power_d = wbyte_q[sac_pkg::PWR_BIT];
			go_d = sw_go;
		end
		if (wr_pcfg && wlane_q)
			pcfg_d = wbyte_q[2:0];
		// software clears the done flag by writing zero to it
		if (wr_stat && wlane_q && !wbyte_q[sac_pkg::DONE_BIT])
			done_flag_d = 1'b0;
		if (core_done && go_q)
		begin
			result_d = core_res;
			done_flag_d = 1'b1; // set wins over a same-cycle clear
			if (!sw_go)
				go_d = 1'b0;
		end
		if (sleep_kill || !power_d)
			go_d = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clk_sel_q <= sac_pkg::CTL_RESET[sac_pkg::CLK_SEL_LSB +: 2];
			chan_q <= sac_pkg::CTL_RESET[sac_pkg::CHAN_LSB +: 3];
			go_q <= sac_pkg::CTL_RESET[sac_pkg::GO_BIT];
			power_q <= sac_pkg::CTL_RESET[sac_pkg::PWR_BIT];
			pcfg_q <= sac_pkg::PCFG_RESET;
			result_q <= sac_pkg::RES_RESET;
			done_flag_q <= 1'b0;
		end
		else
		begin
			clk_sel_q <= clk_sel_d;
			chan_q <= chan_d;
			go_q <= go_d;
			power_q <= power_d;
			pcfg_q <= pcfg_d;
			result_q <= result_d;
			done_flag_q <= done_flag_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// start sequencing: rc conversions wait one instruction cycle so sleep can settle the noise
	assign abort = go_q && !go_d && !core_done;

	always_comb
	begin
		pend_d = pend_q;
		wait_d = wait_q;
		start_d = 1'b0;
		if (sw_go && (!go_q || core_done))
		begin
			pend_d = 1'b1;
			wait_d = (clk_sel_d == sac_pkg::SEL_RC) ? 3'(sac_pkg::START_WAIT_CYC) : 3'h0;
		end
		else if (pend_q)
		begin
			if (wait_q == 3'h0)
			begin
				pend_d = 1'b0;
				start_d = 1'b1;
			end
			else
				wait_d = wait_q - 3'h1;
		end
		if (!go_d)
		begin
			pend_d = 1'b0;
			start_d = 1'b0; // a go killed in its launch cycle must not reach the engine
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pend_q <= 1'b0;
			wait_q <= 3'h0;
			start_q <= 1'b0;
		end
		else
		begin
			pend_q <= pend_d;
			wait_q <= wait_d;
			start_q <= start_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// comparator synchroniser, stages two and three must agree; bit periods under six clocks see stale levels
	assign comp_f_d = (comp_s2_q == comp_s3_q) ? comp_s3_q : comp_f_q;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			comp_s1_q <= 1'b0;
			comp_s2_q <= 1'b0;
			comp_s3_q <= 1'b0;
			comp_f_q <= 1'b0;
		end
		else
		begin
			comp_s1_q <= comp_pin;
			comp_s2_q <= comp_s1_q;
			comp_s3_q <= comp_s2_q;
			comp_f_q <= comp_f_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// conversion clock and search engine
	sac_clk_div #(
		.RC_DIV(RC_DIV)
	) u_div (
		.clk(clk),
		.rst_b(rst_b),
		.run(busy),
		.sel(clk_sel_q),
		.tick(tick)
	);

	sac_sar_core #(
		.RES_W(sac_pkg::RESULT_W)
	) u_core (
		.clk(clk),
		.rst_b(rst_b),
		.tick(tick),
		.start(start_q),
		.abort(abort),
		.comp_high(comp_f_q),
		.busy(busy),
		.done(core_done),
		.sample(core_sample),
		.dac_code(core_dac),
		.result(core_res)
	);

	////////////////////////////////////////////////////////////////
	// analog front-end controls, all registered
	always_comb
	begin
		ana_d.conv_on = power_q && !sleep_kill;
		ana_d.ref_external = sac_pkg::pcfg_ref_ext(pcfg_q);
		ana_d.analog_mask = sac_pkg::pcfg_mask(pcfg_q) & 8'((9'h001 << NUM_CHANNELS) - 9'h001);
		ana_d.channel = chan_q;
		// codes past the last channel of a small variant route nothing
		ana_d.route_en = power_q && (32'(chan_q) < NUM_CHANNELS);
		ana_d.sample = core_sample;
		ana_d.dac_code = core_dac;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ana_q <= '0;
		else
			ana_q <= ana_d;
	end

	assign ana = ana_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule : sac_top

// ==== dv/sac_top_props.sv ====
// port assertions for the converter control block
`timescale 1ns/100ps
module sac_top_props #(
	parameter int NUM_CHANNELS = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire sac_pkg::sac_ana_t ana
);
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////////////
	// analog front-end relations
	property p_route_range;
		ana.route_en |-> ana.channel < NUM_CHANNELS;
	endproperty
	a_route_range: assert property (p_route_range) else $error("mux routed to a missing channel");
	property p_mask_range;
		(ana.analog_mask >> NUM_CHANNELS) == 8'h00;
	endproperty
	a_mask_range: assert property (p_mask_range) else $error("analog pin beyond variant");
	property p_ref_pin;
		ana.ref_external |-> !ana.analog_mask[3];
	endproperty
	a_ref_pin: assert property (p_ref_pin) else $error("input 3 both reference and channel");
	// a powered-down converter must not keep searching
	property p_idle;
		(!ana.conv_on) [*3] |-> ana.dac_code == 8'h00 && !ana.sample;
	endproperty
	a_idle: assert property (p_idle) else $error("engine active while off");

	////////////////////////////////////////////////////////////////////////////////
	// register bus timing
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response late");
	property p_wr_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_block: assert property (p_wr_block) else $error("write accepted during response");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");
	property p_rd_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rd_block: assert property (p_rd_block) else $error("read accepted during response");
endmodule : sac_top_props

bind sac_top sac_top_props #(.NUM_CHANNELS(NUM_CHANNELS)) u_props (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ana);

// ==== dv/sac_ana_model.sv ====
// analog input pins and comparator seen by the converter
`timescale 1ns/100ps
module sac_ana_model (
	input wire logic clk,
	input wire sac_pkg::sac_ana_t ana,
	input wire logic [7:0] level [8],
	output logic comp_pin
);
	logic tog_q = 1'h0;

	// toggles so an unrouted comparator never looks like a steady answer
	always_ff @(posedge clk)
		tog_q <= ~tog_q;

	// held level against the trial code; high keeps the trial bit
	always_comb
		if (ana.conv_on && ana.route_en)
			comp_pin = level[ana.channel] >= ana.dac_code;
		else
			comp_pin = tog_q;
endmodule : sac_ana_model

// ==== dv/tb_sac_top.sv ====
// self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_sac_top;
	localparam int NCH = 5;
	// rc bit period kept above the comparator synchroniser latency
	localparam int RCD = 8;
	localparam logic [11:0] A_CTL = 12'h07C;
	localparam logic [11:0] A_PCF = 12'h27C;
	localparam logic [11:0] A_RES = 12'h078;
	localparam logic [11:0] A_STA = 12'h030;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, sleep_mode = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, comp_pin;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	sac_pkg::sac_ana_t ana;
	logic [7:0] lvl [8] = '{8{8'h00}};
	logic [7:0] last;
	logic [2:0] ch;
	integer seed = 32'hC053;
	int error_cnt = 0;
	int cmp_count = 0;
	int tick = 0;
	int el;

	////////////////////////////////////////////////////////////////////////////////
	// clock, cycle count, design and far side
	always #5 clk = ~clk;
	always @(posedge clk)
		tick <= tick + 1;
	sac_top #(.NUM_CHANNELS(NCH), .RC_DIV(RCD)) uut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sleep_mode, .comp_pin, .ana);
	sac_ana_model u_far (.clk, .ana, .level(lvl), .comp_pin);

	////////////////////////////////////////////////////////////////////////////////
	// expectations and bus tasks
	function automatic int per(input logic [1:0] s);
		return s == 2'h0 ? 2 : s == 2'h1 ? 8 : s == 2'h2 ? 32 : RCD;
	endfunction : per
	// analog pins per port setting, channel 0..7, cut to the small variant
	function automatic logic [7:0] amask(input logic [2:0] c);
		logic [7:0] t [8] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00};
		return t[c] & 8'h1F;
	endfunction : amask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		// only the watchdog ends a wait for the response
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		chk(32'(s_axi_bresp), 32'(er), "write response");
	endtask : wr
	task automatic rdreg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rdreg
	task automatic rchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		rdreg(a, rd, rsp);
		chk(rd, ed, "read data");
		chk(32'(rsp), 32'(er), "read response");
	endtask : rchk
	// power first, go in a later write, as the converter requires
	task automatic start(input logic [1:0] s, input logic [2:0] c);
		wr(A_CTL, {24'h0, s, c, 3'h1}, 2'h0);
		wr(A_CTL, {24'h0, s, c, 3'h5}, 2'h0);
	endtask : start
	task automatic convert(input logic [1:0] s, input logic [2:0] c);
		int t0;
		int n;
		start(s, c);
		t0 = tick;
		n = 0;
		do
		begin
			rdreg(A_CTL, rd, rsp);
			n++;
		end
		while (rd[2] !== 1'h0 && n < 1000);
		el = tick - t0;
	endtask : convert
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////////
	// watchdog, well beyond the expected run of under fifteen hundred cycles
	initial
	begin
		#200000;
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run();
	end

	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
		rchk(A_CTL, 32'h0, 2'h0);
		rchk(A_PCF, 32'h0, 2'h0);
		rchk(A_RES, 32'h0, 2'h0);
		rchk(A_STA, 32'h0, 2'h0);
		rchk(12'h400, 32'h0, 2'h2);
		wr(12'h400, 32'h1, 2'h2);
		wr(A_CTL, 32'hFFFFFFFB, 2'h0);
		rchk(A_CTL, 32'hF9, 2'h0);
		wr(A_RES, 32'h55, 2'h0);
		rchk(A_RES, 32'h0, 2'h0);
		// every channel code, codes past the variant must stay unrouted
		for (int c = 0; c < 8; c++)
		begin
			wr(A_CTL, {24'h0, 2'h0, 3'(c), 3'h1}, 2'h0);
			repeat (2) @(posedge clk);
			chk(32'(ana.channel), 32'(c), "channel");
			chk(32'(ana.route_en), 32'(c < NCH), "route");
			chk(32'(ana.conv_on), 32'h1, "power on");
		end
		wr(A_CTL, 32'h0, 2'h0);
		repeat (2) @(posedge clk);
		chk(32'(ana.conv_on), 32'h0, "power off");
		// every port setting: pin mask and reference source
		for (int c = 0; c < 8; c++)
		begin
			wr(A_PCF, 32'(c), 2'h0);
			repeat (2) @(posedge clk);
			chk(32'(ana.analog_mask), 32'(amask(3'(c))), "pin mask");
			chk(32'(ana.ref_external), 32'(c % 2 == 1 && c < 6), "reference");
			rchk(A_PCF, 32'(c), 2'h0);
		end
		wr(A_PCF, 32'h0, 2'h0);
		// a write with byte lane 0 disabled must leave the register alone
		s_axi_wstrb <= 4'hE;
		wr(A_PCF, 32'h5, 2'h0);
		s_axi_wstrb <= 4'hF;
		rchk(A_PCF, 32'h0, 2'h0);
		// each clock source, full and empty scale among random levels
		for (int s = 0; s < 4; s++)
		begin
			ch = 3'($unsigned($random(seed)) % NCH);
			lvl[ch] <= s == 0 ? 8'hFF : s == 1 ? 8'h00 : 8'($random(seed));
			convert(2'(s), ch);
			chk(32'(el >= 9 * per(2'(s)) && el <= 9 * per(2'(s)) + 24), 32'h1, "conversion time");
			rchk(A_RES, {24'h0, lvl[ch]}, 2'h0);
			rchk(A_STA, 32'h1, 2'h0);
			wr(A_STA, 32'h0, 2'h0);
			rchk(A_STA, 32'h0, 2'h0);
			last = lvl[ch];
		end
		// abort by clearing go mid-way
		lvl[ch] <= ~last;
		start(2'h2, ch);
		repeat (40) @(posedge clk);
		wr(A_CTL, {24'h0, 2'h2, ch, 3'h1}, 2'h0);
		repeat (400) @(posedge clk);
		rchk(A_RES, {24'h0, last}, 2'h0);
		rchk(A_STA, 32'h0, 2'h0);
		// sleep: rc clock finishes, system clock is aborted
		sleep_mode <= 1'h1;
		convert(2'h3, ch);
		rchk(A_RES, {24'h0, lvl[ch]}, 2'h0);
		wr(A_STA, 32'h0, 2'h0);
		sleep_mode <= 1'h0;
		lvl[ch] <= 8'h5A;
		start(2'h1, ch);
		repeat (20) @(posedge clk);
		sleep_mode <= 1'h1;
		repeat (100) @(posedge clk);
		rchk(A_CTL, {24'h0, 2'h1, ch, 3'h1}, 2'h0);
		chk(32'(ana.conv_on), 32'h0, "sleep power");
		rchk(A_RES, {24'h0, ~last}, 2'h0);
		rchk(A_STA, 32'h0, 2'h0);
		sleep_mode <= 1'h0;
		complete_run();
	end
endmodule : tb_sac_top
